// file: hw/rcs_ctrl_regs.sv
// Control and status registers of a real-time clock: divider control,
// rate select, modes, read-to-clear flags, battery status.
// Assumes bus pins synchronous to mclk; time bytes come from a core outside.
module rcs_ctrl_regs (
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  input  wire rcs_pkg::rcs_bus_in_type    bus_in,
  output logic [7:0]                      data_out,
  output logic                            data_oe,
  output logic                            irq_n,
  output logic                            square_wave_out,
  input  wire logic                       battery_valid,
  input  wire rcs_pkg::rcs_time_type      time_in,
  output rcs_pkg::rcs_core_ctrl_type      core_ctrl
);

  rcs_pkg::rcs_state_type s_r;
  rcs_pkg::rcs_state_type s_nxt;

  function automatic logic [3:0] tap_index(input logic [3:0] rs);
    if (rs == rcs_pkg::RS_DUP_256) begin
      tap_index = rcs_pkg::TAP_256;
    end else if (rs == rcs_pkg::RS_DUP_128) begin
      tap_index = rcs_pkg::TAP_128;
    end else begin
      tap_index = rs - rcs_pkg::TAP_OFFSET;
    end
  endfunction

  function automatic logic alarm_hit(input logic [7:0] t,
                                     input logic [7:0] a);
    alarm_hit = (a[7:6] == rcs_pkg::ALARM_WILD) || (a == t);
  endfunction

  function automatic rcs_pkg::rcs_flags_type enables(
      input rcs_pkg::rcs_regb_type rb);
    enables = {rb.periodic_en, rb.alarm_en, rb.update_end_en};
  endfunction

  function automatic logic osc_on(input logic [2:0] dv);
    osc_on = (dv == rcs_pkg::DV_RUN) || (dv[2:1] == rcs_pkg::DV_HOLD_TOP);
  endfunction

  logic                   run;
  logic                   tick;
  logic                   tap;
  logic                   upd_evt;
  logic                   wr_end;
  logic                   rd_now;
  logic                   rd_c;
  logic                   intr_request_flag;
  logic [7:0]             rd_data;
  rcs_pkg::rcs_flags_type ev;

  always_comb begin
    s_nxt = s_r;
    s_nxt.upd_strobe = 1'b0;

    // Time base and divider chain
    run  = (s_r.ra.divider_ctrl == rcs_pkg::DV_RUN);
    tick = osc_on(s_r.ra.divider_ctrl) &&
           (s_r.tick_cnt == rcs_pkg::TICK_LAST);
    if (!osc_on(s_r.ra.divider_ctrl) || tick) begin
      s_nxt.tick_cnt = '0;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 12'h001;
    end
    // Held at the half-second point so the first wrap lands 500 ms on
    if (!run) begin
      s_nxt.div = rcs_pkg::DIV_PRESET;
    end else if (tick) begin
      s_nxt.div = s_r.div + 15'h0001;
    end
    upd_evt = run && tick && (s_r.div == rcs_pkg::DIV_LAST);
    s_nxt.upd_strobe = upd_evt && !s_r.rb.update_freeze;

    // Rate tap shared by square wave and periodic flag; a stopped chain
    // shows no tap, so a stale divider value cannot glitch the pin
    if (!run || s_r.ra.rate_sel == rcs_pkg::RS_NONE) begin
      tap = 1'b0;
    end else begin
      tap = s_r.div[tap_index(s_r.ra.rate_sel)];
    end
    s_nxt.tap_d = tap;

    ev.periodic_flag   = tap && !s_r.tap_d;
    ev.alarm_flag      = upd_evt &&
                         alarm_hit(time_in.sec, time_in.alarm_sec) &&
                         alarm_hit(time_in.min, time_in.alarm_min) &&
                         alarm_hit(time_in.hour, time_in.alarm_hour);
    ev.update_end_flag = upd_evt;

    // Host bus: writes commit on the rising edge of the write strobe
    s_nxt.wr_act = !bus_in.wr_n && !bus_in.rtc_select_n;
    s_nxt.a0     = bus_in.addr0;
    s_nxt.din    = bus_in.data_in;
    wr_end = s_r.wr_act && bus_in.wr_n;
    if (wr_end && !s_r.a0) begin
      s_nxt.index = s_r.din;
    end else if (wr_end && s_r.index == rcs_pkg::IDX_A) begin
      s_nxt.ra.divider_ctrl = s_r.din[6:4];
      s_nxt.ra.rate_sel     = s_r.din[3:0];
    end else if (wr_end && s_r.index == rcs_pkg::IDX_B) begin
      s_nxt.rb = s_r.din;
      if (s_r.din[7] && !s_r.rb.update_freeze) begin
        s_nxt.rb.update_end_en = 1'b0;
      end
    end

    // Transfer warning window, dropped at once by freeze
    s_nxt.ra.update_pending = (s_nxt.ra.divider_ctrl == rcs_pkg::DV_RUN) &&
                              !s_nxt.rb.update_freeze &&
                              (s_nxt.div >= rcs_pkg::PEND_START);

    // Flags: frozen during a read of the flag register, cleared at its end
    rd_now = !bus_in.rd_n && !bus_in.rtc_select_n;
    rd_c   = rd_now && bus_in.addr0 && (s_r.index == rcs_pkg::IDX_C);
    if (s_r.c_reading) begin
      if (!rd_c) begin
        s_nxt.flags     = s_r.hold | ev;
        s_nxt.hold      = rcs_pkg::FLAGS_RST;
        s_nxt.c_reading = 1'b0;
      end else begin
        s_nxt.hold = s_r.hold | ev;
      end
    end else if (rd_c) begin
      s_nxt.c_reading = 1'b1;
      s_nxt.hold      = ev;
    end else begin
      s_nxt.flags = s_r.flags | ev;
    end

    intr_request_flag = |(s_r.flags & enables(s_r.rb));
    s_nxt.irq_n = !(|(s_nxt.flags & enables(s_nxt.rb)));

    // Read data
    s_nxt.batt = battery_valid;
    if (!bus_in.addr0) begin
      rd_data = s_r.index;
    end else if (s_r.index == rcs_pkg::IDX_A) begin
      rd_data = s_r.ra;
    end else if (s_r.index == rcs_pkg::IDX_B) begin
      rd_data = s_r.rb;
    end else if (s_r.index == rcs_pkg::IDX_C) begin
      rd_data = {intr_request_flag, s_r.flags, 4'h0};
    end else if (s_r.index == rcs_pkg::IDX_D) begin
      rd_data = {s_r.batt, 7'h00};
    end else begin
      rd_data = 8'h00;
    end
    s_nxt.dout = rd_now ? rd_data : 8'h00;
    s_nxt.doe  = rd_now;

    s_nxt.wave        = s_nxt.rb.sqw_en && tap;
    s_nxt.osc_run     = osc_on(s_nxt.ra.divider_ctrl);
    s_nxt.chain_reset = s_nxt.ra.divider_ctrl != rcs_pkg::DV_RUN;
  end

  // Reset clears enables and flags; other mode bits get defined values
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= rcs_pkg::STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign data_out                = s_r.dout;
  assign data_oe                 = s_r.doe;
  assign irq_n                   = s_r.irq_n;
  assign square_wave_out         = s_r.wave;
  assign core_ctrl               = '{osc_run:       s_r.osc_run,
                                     chain_reset:   s_r.chain_reset,
                                     update_strobe: s_r.upd_strobe,
                                     data_format:   s_r.rb.data_format,
                                     hour_format:   s_r.rb.hour_format,
                                     dst_en:        s_r.rb.dst_en};

endmodule // rcs_ctrl_regs

// file: hw/rcs_pkg.sv
// Constants and carrier types for the clock control/status register block.
// Assumes a 125 MHz system clock and a host on an indexed byte-wide bus.
package rcs_pkg;

  // Time base
  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned BASE_HZ         = 32768;
  localparam int unsigned TICK_DIV        = CLK_HZ / BASE_HZ;
  localparam logic [11:0] TICK_LAST       = 12'(TICK_DIV - 1);
  localparam int unsigned PEND_LEAD_US    = 244;
  localparam int unsigned PEND_LEAD_TICKS =
    (PEND_LEAD_US * BASE_HZ + 999999) / 1000000;
  localparam int unsigned FIRST_UPDATE_MS = 500;
  localparam logic [14:0] DIV_PRESET      =
    15'(FIRST_UPDATE_MS * BASE_HZ / 1000);
  localparam logic [14:0] DIV_LAST        = 15'h7fff;
  localparam logic [14:0] PEND_START      = 15'(BASE_HZ - PEND_LEAD_TICKS);

  // Register indices behind the index register
  localparam logic [7:0] IDX_A = 8'h0a;
  localparam logic [7:0] IDX_B = 8'h0b;
  localparam logic [7:0] IDX_C = 8'h0c;
  localparam logic [7:0] IDX_D = 8'h0d;

  // Field encodings
  localparam logic [2:0] DV_RUN      = 3'b010;
  localparam logic [1:0] DV_HOLD_TOP = 2'b11;
  localparam logic [3:0] RS_NONE     = 4'h0;
  localparam logic [3:0] RS_DUP_256  = 4'h1;
  localparam logic [3:0] RS_DUP_128  = 4'h2;
  localparam logic [3:0] TAP_256     = 4'h6;
  localparam logic [3:0] TAP_128     = 4'h7;
  localparam logic [3:0] TAP_OFFSET  = 4'h2;
  localparam logic [1:0] ALARM_WILD  = 2'b11;

  typedef struct packed {
    logic       update_pending;
    logic [2:0] divider_ctrl;
    logic [3:0] rate_sel;
  } rcs_rega_type;

  typedef struct packed {
    logic update_freeze;
    logic periodic_en;
    logic alarm_en;
    logic update_end_en;
    logic sqw_en;
    logic data_format;
    logic hour_format;
    logic dst_en;
  } rcs_regb_type;

  typedef struct packed {
    logic periodic_flag;
    logic alarm_flag;
    logic update_end_flag;
  } rcs_flags_type;

  localparam rcs_rega_type  RA_RST    = '{default: 1'b0};
  localparam rcs_regb_type  RB_RST    = '{default: 1'b0};
  localparam rcs_flags_type FLAGS_RST = '{default: 1'b0};

  typedef struct packed {
    logic       ram_select_n;
    logic       rtc_select_n;
    logic       addr0;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] data_in;
  } rcs_bus_in_type;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] alarm_sec;
    logic [7:0] alarm_min;
    logic [7:0] alarm_hour;
  } rcs_time_type;

  typedef struct packed {
    logic osc_run;
    logic chain_reset;
    logic update_strobe;
    logic data_format;
    logic hour_format;
    logic dst_en;
  } rcs_core_ctrl_type;

  typedef struct packed {
    logic          wr_act;
    logic          a0;
    logic [7:0]    din;
    logic [7:0]    index;
    rcs_rega_type  ra;
    rcs_regb_type  rb;
    rcs_flags_type flags;
    rcs_flags_type hold;
    logic          c_reading;
    logic [11:0]   tick_cnt;
    logic [14:0]   div;
    logic          tap_d;
    logic          batt;
    logic [7:0]    dout;
    logic          doe;
    logic          irq_n;
    logic          wave;
    logic          osc_run;
    logic          chain_reset;
    logic          upd_strobe;
  } rcs_state_type;

  localparam rcs_state_type STATE_RST = '{
    ra: RA_RST, rb: RB_RST, flags: FLAGS_RST, hold: FLAGS_RST,
    irq_n: 1'b1, default: '0};

endpackage

// file: test/rcs_ctrl_regs_props.sv
// Port-level assertions for the clock control register block.
// Assumes it is bound to rcs_ctrl_regs and sees only its ports.
module rcs_ctrl_props (
  input wire logic                       mclk,
  input wire logic                       nrst,
  input wire rcs_pkg::rcs_bus_in_type    bus_in,
  input wire logic [7:0]                 data_out,
  input wire logic                       data_oe,
  input wire logic                       square_wave_out,
  input wire rcs_pkg::rcs_core_ctrl_type core_ctrl
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_rd;
    !bus_in.rd_n && !bus_in.rtc_select_n;
  endsequence
  sequence s_idle;
    bus_in.rd_n || bus_in.rtc_select_n;
  endsequence
  property p_oe_on; s_rd |=> data_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("no drive");
  property p_oe_off; s_idle |=> !data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("stuck drive");
  property p_dout0; !data_oe |-> data_out == 8'h00; endproperty
  a_dout0: assert property (p_dout0) else $error("idle data");
  property p_chain;
    $past(nrst) && !core_ctrl.osc_run |-> core_ctrl.chain_reset;
  endproperty
  a_chain: assert property (p_chain) else $error("chain free");
  property p_pulse;
    core_ctrl.update_strobe |=> !core_ctrl.update_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long strobe");
  property p_run;
    core_ctrl.update_strobe |->
      $past(core_ctrl.osc_run) && !$past(core_ctrl.chain_reset);
  endproperty
  a_run: assert property (p_run) else $error("update halted");
  property p_fmt;
    $changed({core_ctrl.data_format, core_ctrl.hour_format, core_ctrl.dst_en})
      |-> $past(bus_in.wr_n) && !$past(bus_in.wr_n, 2);
  endproperty
  a_fmt: assert property (p_fmt) else $error("mode changed");
  property p_wave; $rose(square_wave_out) |-> $past(core_ctrl.osc_run);
  endproperty
  a_wave: assert property (p_wave) else $error("wave with osc off");
endmodule // rcs_ctrl_props

bind rcs_ctrl_regs rcs_ctrl_props u_props (.mclk(mclk), .nrst(nrst),
  .bus_in(bus_in), .data_out(data_out), .data_oe(data_oe),
  .square_wave_out(square_wave_out), .core_ctrl(core_ctrl));

// file: test/rcs_host.sv
// Host model: indexed byte access, index write then data access.
// Assumes strobes move just after mclk rising edges.
module rcs_host (
  input  wire logic              mclk,
  input  wire logic [7:0]        data_out,
  output rcs_pkg::rcs_bus_in_type bus_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bus_in = '{ram_select_n: 1'b1, rtc_select_n: 1'b1, rd_n: 1'b1,
                     wr_n: 1'b1, default: '0};
  task automatic put(input logic a, input logic [7:0] d);
    @(posedge mclk);
    bus_in.rtc_select_n <= 1'b0;
    bus_in.addr0 <= a;
    bus_in.wr_n <= 1'b0;
    bus_in.data_in <= d;
    @(posedge mclk);
    bus_in.wr_n <= 1'b1;
    @(posedge mclk);
    bus_in.rtc_select_n <= 1'b1;
    // Released data must not keep looking valid
    bus_in.data_in <= ~d;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    put(1'b0, idx);
    put(1'b1, v);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    put(1'b0, idx);
    @(posedge mclk);
    bus_in.rtc_select_n <= 1'b0;
    bus_in.addr0 <= 1'b1;
    bus_in.rd_n <= 1'b0;
    @(posedge mclk);
    @(posedge mclk);
    // Data registered at the edge that took the strobe stands here
    v = data_out;
    bus_in.rd_n <= 1'b1;
    bus_in.rtc_select_n <= 1'b1;
  endtask
endmodule // rcs_host

// file: test/tb_top.sv
// Self-checking bench for the clock control register block.
// Assumes the host model drives the bus and time bytes stay constant.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       mclk, nrst, batt, wave, irq_n, oe, p;
  logic [7:0]                 dout, v;
  rcs_pkg::rcs_bus_in_type    bus;
  rcs_pkg::rcs_time_type      tm;
  rcs_pkg::rcs_core_ctrl_type cc;
  int                         error_cnt, samples_checked, n;
  rcs_ctrl_regs dut_u (.mclk(mclk), .nrst(nrst), .bus_in(bus),
    .data_out(dout), .data_oe(oe), .irq_n(irq_n), .square_wave_out(wave),
    .battery_valid(batt), .time_in(tm), .core_ctrl(cc));
  rcs_host host_u (.mclk(mclk), .data_out(dout), .bus_in(bus));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task rdc(input logic [7:0] idx, input logic [7:0] e, input string m);
    host_u.rd(idx, v);
    chk(v === e, m);
  endtask
  task tog(input int c);
    n = 0;
    p = wave;
    repeat (c) begin
      @(posedge mclk);
      if (wave !== p) n++;
      p = wave;
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task t_reset;
    rdc(8'h0a, 8'h00, "A reset");
    rdc(8'h0b, 8'h00, "B reset");
    rdc(8'h0c, 8'h00, "C reset");
    rdc(8'h0d, 8'h80, "D valid");
    batt <= 1'b0;
    rdc(8'h0d, 8'h00, "D invalid");
    batt <= 1'b1;
    rdc(8'h0e, 8'h00, "unmapped");
    $display("t_reset done");
  endtask
  task t_regs;
    host_u.wr(8'h0b, 8'h37);
    rdc(8'h0b, 8'h37, "B rw");
    chk(cc.data_format & cc.hour_format & cc.dst_en, "modes");
    host_u.wr(8'h0b, 8'hb7);
    rdc(8'h0b, 8'ha7, "freeze");
    host_u.wr(8'h0a, 8'hff);
    rdc(8'h0a, 8'h7f, "A pending");
    chk(cc.osc_run === 1'b1 && cc.chain_reset === 1'b1, "hold");
    host_u.wr(8'h0a, 8'h40);
    rdc(8'h0a, 8'h40, "A off");
    chk(cc.osc_run === 1'b0, "osc off");
    host_u.wr(8'h0c, 8'hff);
    host_u.wr(8'h0d, 8'hff);
    rdc(8'h0c, 8'h00, "C ro");
    rdc(8'h0d, 8'h80, "D ro");
    host_u.wr(8'h0b, 8'h00);
    $display("t_regs done");
  endtask
  task t_periodic;
    host_u.wr(8'h0a, 8'h23);
    repeat (20000) @(posedge mclk);
    chk(irq_n === 1'b1, "masked");
    rdc(8'h0c, 8'h40, "pf set");
    rdc(8'h0c, 8'h00, "read clears");
    chk(cc.osc_run === 1'b1 && cc.chain_reset === 1'b0, "run");
    host_u.wr(8'h0b, 8'h40);
    repeat (16000) @(posedge mclk);
    chk(irq_n === 1'b0, "irq low");
    rdc(8'h0c, 8'hc0, "request flag");
    repeat (2) @(posedge mclk);
    chk(irq_n === 1'b1, "irq release");
    $display("t_periodic done");
  endtask
  task t_wave;
    host_u.wr(8'h0b, 8'h08);
    // Fastest tap: four toggles in two periods, phase unknown
    tog(30512);
    chk(n >= 3 && n <= 5, "wave");
    host_u.wr(8'h0b, 8'h00);
    repeat (4) @(posedge mclk);
    tog(9000);
    chk(n == 0 && wave === 1'b0, "held low");
    $display("t_wave done");
  endtask
  task t_midreset;
    host_u.wr(8'h0b, 8'h78);
    @(posedge mclk);
    chk(irq_n === 1'b0, "irq before reset");
    // Reset in mid-run must drop enables, flags and pins at once
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    chk(irq_n === 1'b1, "irq reset");
    chk(wave === 1'b0, "wave reset");
    rdc(8'h0b, 8'h00, "B cleared");
    rdc(8'h0c, 8'h00, "C cleared");
    $display("t_midreset done");
  endtask
  initial begin
    nrst = 1'b0;
    batt = 1'b1;
    tm = '{default: 8'hc0};
    error_cnt = 0;
    samples_checked = 0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_periodic();
    t_wave();
    t_midreset();
    give_verdict();
  end
  initial begin
    #800us;
    error_cnt++;
    $display("[ERR] %0t timeout", $time);
    give_verdict();
  end
endmodule // tb_top
